//--- hw/uarts_core.sv
// uarts_core: APB-attached asynchronous serial transceiver with bit-tick
// generation, noise filter, majority sampling, transmit and receive paths.
// assumes serial_rx_pin_in is asynchronous; everything else is on clk_in.
`timescale 1ns/1ns
module uarts_core
  import uarts_pkg::*;
(
  input wire logic clk_in, // 100 MHz system clock
  input wire logic rst_n_in, // synchronous reset, active low
  input wire logic psel_in, // apb select
  input wire logic penable_in, // apb enable
  input wire logic pwrite_in, // apb direction, high writes
  input wire logic [7:0] paddr_in, // apb byte address
  input wire logic [31:0] pwdata_in, // apb write data
  output logic [31:0] prdata_out, // apb read data
  output logic pready_out, // apb ready
  output logic pslverr_out, // apb error on unmapped address
  input wire logic serial_rx_pin_in, // asynchronous receive line
  output logic serial_tx_pin_out, // transmit line
  output logic tx_interrupt_request_out, // one-cycle transmit request
  output logic rx_interrupt_request_out // one-cycle receive request
);

  typedef enum logic [1:0] {
    UARTS_IDLE = 2'b01,
    UARTS_BUSY = 2'b10
  } uarts_state_t;

  // ************************************
  // helper functions
  // ************************************
  // tick count minus one for bit number idx
  function automatic logic [4:0] bit_top(input logic [2:0] sel, input logic [3:0] idx);
    logic [4:0] top;
    top = 5'h0F;
    unique case (sel)
      3'h1: top = idx[0] ? 5'h10 : 5'h0F;
      3'h2: top = 5'h0E;
      3'h3: top = idx[0] ? 5'h0F : 5'h0E;
      3'h4: top = 5'h10;
      default: top = 5'h0F;
    endcase
    return top;
  endfunction

  function automatic logic [3:0] last_idx(input uarts_cfg_t c);
    return UARTS_FIRST_TAIL_IDX + {3'h0, c.pe} + {3'h0, c.stb};
  endfunction

  function automatic logic maj3(input logic a, input logic b, input logic c);
    return (a & b) | (a & c) | (b & c);
  endfunction

  // ************************************
  // registers
  // ************************************
  uarts_cfg_t cfg_ff;
  logic [2:0] ticks_per_bit_select_ff;
  logic [1:0] nfsel_ff;
  logic [7:0] divisor_ff;
  logic [7:0] tx_buf_ff;
  logic tx_buffer_full_flag_ff;
  logic [7:0] rx_buf_ff;
  uarts_rxflag_t flag_ff;
  uarts_rxflag_t snap_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic [31:0] prdata_ff;

  logic acc_done;
  logic wr_done;
  logic rd_done;
  logic mapped;
  logic status_rd;
  logic rxbuf_rd;
  logic txbuf_wr;

  assign acc_done = psel_in & penable_in & pready_ff;
  assign wr_done = acc_done & pwrite_in;
  assign rd_done = acc_done & ~pwrite_in;
  assign status_rd = rd_done & (paddr_in == UARTS_STATUS_OFS);
  assign rxbuf_rd = rd_done & (paddr_in == UARTS_RX_BUF_OFS);
  assign txbuf_wr = wr_done & (paddr_in == UARTS_TX_BUF_OFS);

  always_comb begin
    unique case (paddr_in)
      UARTS_CTRL_ONE_OFS, UARTS_CTRL_TWO_OFS, UARTS_DIVISOR_OFS,
      UARTS_STATUS_OFS, UARTS_TX_BUF_OFS, UARTS_RX_BUF_OFS: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // ************************************
  // apb slave: one wait state per access
  // ************************************
  logic tx_busy;
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end else if (psel_in && penable_in && !pready_ff) begin
      pready_ff <= 1'b1;
      pslverr_ff <= ~mapped;
      prdata_ff <= 32'h0000_0000;
      if (!pwrite_in) begin
        unique case (paddr_in)
          UARTS_CTRL_ONE_OFS: prdata_ff <= {22'h0, cfg_ff.baud_clock_source_select, 1'b0, cfg_ff.lpm,
              cfg_ff.irda, cfg_ff.stb, cfg_ff.odd, cfg_ff.pe, cfg_ff.receive_enable_bit, cfg_ff.txe};
          UARTS_CTRL_TWO_OFS: prdata_ff <= {27'h0, nfsel_ff, ticks_per_bit_select_ff};
          UARTS_DIVISOR_OFS: prdata_ff <= {24'h0, divisor_ff};
          UARTS_STATUS_OFS: prdata_ff <= {26'h0, tx_busy, tx_buffer_full_flag_ff, flag_ff};
          UARTS_RX_BUF_OFS: prdata_ff <= {24'h0, rx_buf_ff};
          default: prdata_ff <= 32'h0000_0000;
        endcase
      end
    end else begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      cfg_ff <= '0;
      ticks_per_bit_select_ff <= 3'h0;
      nfsel_ff <= 2'h0;
      divisor_ff <= UARTS_DIVISOR_RST;
    end else if (wr_done) begin
      if (paddr_in == UARTS_CTRL_ONE_OFS) begin
        cfg_ff <= {pwdata_in[UARTS_C1_BRG_LO+1:UARTS_C1_BRG_LO], pwdata_in[UARTS_C1_LPM],
            pwdata_in[UARTS_C1_IRDA], pwdata_in[UARTS_C1_STB], pwdata_in[UARTS_C1_ODD],
            pwdata_in[UARTS_C1_PE], pwdata_in[UARTS_C1_RXE], pwdata_in[UARTS_C1_TXE]};
      end
      if (paddr_in == UARTS_CTRL_TWO_OFS) begin
        ticks_per_bit_select_ff <= pwdata_in[UARTS_C2_RTS_LO+2:UARTS_C2_RTS_LO];
        nfsel_ff <= pwdata_in[UARTS_C2_NF_LO+1:UARTS_C2_NF_LO];
      end
      if (paddr_in == UARTS_DIVISOR_OFS) begin
        divisor_ff <= pwdata_in[7:0];
      end
    end
  end

  // ************************************
  // base clock and bit tick
  // ************************************
  logic [2:0] presc_ff;
  logic [7:0] div_cnt_ff;
  logic base_pulse;
  logic tick;

  always_comb begin
    unique case (cfg_ff.baud_clock_source_select)
      2'h1: base_pulse = (presc_ff[0] == 1'b0);
      2'h2: base_pulse = (presc_ff[1:0] == 2'h0);
      2'h3: base_pulse = (presc_ff == 3'h0);
      default: base_pulse = 1'b1;
    endcase
  end
  // one tick every divisor+1 base periods
  assign tick = base_pulse & (div_cnt_ff == divisor_ff);

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      presc_ff <= 3'h0;
      div_cnt_ff <= 8'h00;
    end else begin
      presc_ff <= presc_ff + 3'h1;
      if (base_pulse) begin
        div_cnt_ff <= tick ? 8'h00 : div_cnt_ff + 8'h01;
      end
    end
  end

  // ************************************
  // rx synchroniser and noise filter
  // ************************************
  logic rx_meta_ff;
  logic rx_sync_ff;
  logic rx_filt_ff;
  logic rx_prev_ff;
  logic [2:0] flt_cnt_ff;
  logic [2:0] flt_need;

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      rx_meta_ff <= 1'b1;
      rx_sync_ff <= 1'b1;
    end else begin
      rx_meta_ff <= serial_rx_pin_in;
      rx_sync_ff <= rx_meta_ff;
    end
  end

  // a tick is divisor+1 base periods, so k stable ticks rejects k-1 tick periods, passes k
  always_comb begin
    unique case (nfsel_ff)
      2'h1: flt_need = 3'h1;
      2'h2: flt_need = 3'h2;
      2'h3: flt_need = 3'h4;
      default: flt_need = 3'h0;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      rx_filt_ff <= 1'b1;
      flt_cnt_ff <= 3'h0;
    end else if (nfsel_ff == 2'h0) begin
      rx_filt_ff <= rx_sync_ff;
      flt_cnt_ff <= 3'h0;
    end else if (rx_sync_ff == rx_filt_ff) begin
      flt_cnt_ff <= 3'h0;
    end else if (tick) begin
      if (flt_cnt_ff + 3'h1 >= flt_need) begin
        rx_filt_ff <= rx_sync_ff;
        flt_cnt_ff <= 3'h0;
      end else begin
        flt_cnt_ff <= flt_cnt_ff + 3'h1;
      end
    end
  end

  // ************************************
  // receiver
  // ************************************
  uarts_state_t rx_state_ff;
  logic [4:0] rx_cnt_ff;
  logic [3:0] rx_idx_ff;
  logic [1:0] rx_samp_ff;
  logic [7:0] rx_shift_ff;
  logic rx_par_ff;
  logic rx_stop_bad_ff;
  logic rx_discard_ff;
  logic rx_vote;
  logic rx_decide;
  logic rx_end;
  logic rx_ovr_set;
  logic rx_load;
  logic rx_parity_error_flag_set;
  logic rx_framing_error_flag_set;
  logic rx_irq;

  assign rx_vote = maj3(rx_samp_ff[1], rx_samp_ff[0], rx_filt_ff);
  // ticks 8..6 sit the same distance before the end of every bit whatever its length
  assign rx_decide = (rx_state_ff == UARTS_BUSY) & tick & (rx_cnt_ff == UARTS_SAMPLE_C);
  assign rx_end = rx_decide & (rx_idx_ff == last_idx(cfg_ff));
  assign rx_ovr_set = rx_decide & (rx_idx_ff == UARTS_LAST_DATA_IDX) & flag_ff.rx_buffer_full_flag
      & ~rx_discard_ff;
  assign rx_load = rx_end & ~rx_discard_ff;
  assign rx_parity_error_flag_set = rx_load & cfg_ff.pe
      & (rx_par_ff != (^rx_shift_ff ^ cfg_ff.odd));
  assign rx_framing_error_flag_set = rx_load & (rx_stop_bad_ff | ~rx_vote);
  // a frame dropped while overrun already stands raises nothing
  assign rx_irq = rx_load | (rx_ovr_set & ~flag_ff.overrun_error_flag);

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      rx_state_ff <= UARTS_IDLE;
      rx_cnt_ff <= 5'h00;
      rx_idx_ff <= 4'h0;
      rx_samp_ff <= 2'h0;
    end else if (!cfg_ff.receive_enable_bit) begin
      rx_state_ff <= UARTS_IDLE;
    end else begin
      unique case (rx_state_ff)
        UARTS_IDLE: begin
          if (rx_prev_ff && !rx_filt_ff) begin
            rx_state_ff <= UARTS_BUSY;
            rx_cnt_ff <= bit_top(ticks_per_bit_select_ff, 4'h0);
            rx_idx_ff <= 4'h0;
          end
        end
        UARTS_BUSY: begin
          if (tick) begin
            if (rx_cnt_ff == UARTS_SAMPLE_A) rx_samp_ff[1] <= rx_filt_ff;
            if (rx_cnt_ff == UARTS_SAMPLE_B) rx_samp_ff[0] <= rx_filt_ff;
            if (rx_decide && rx_idx_ff == 4'h0 && rx_vote) begin
              rx_state_ff <= UARTS_IDLE;
            end else if (rx_end) begin
              rx_state_ff <= UARTS_IDLE;
            end else if (rx_cnt_ff == 5'h00) begin
              rx_idx_ff <= rx_idx_ff + 4'h1;
              rx_cnt_ff <= bit_top(ticks_per_bit_select_ff, rx_idx_ff + 4'h1);
            end else begin
              rx_cnt_ff <= rx_cnt_ff - 5'h01;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      rx_shift_ff <= 8'h00;
      rx_par_ff <= 1'b0;
      rx_stop_bad_ff <= 1'b0;
      rx_discard_ff <= 1'b0;
    end else if (rx_decide) begin
      if (rx_idx_ff == 4'h0) begin
        rx_stop_bad_ff <= 1'b0;
        rx_discard_ff <= 1'b0;
      end else if (rx_idx_ff <= UARTS_LAST_DATA_IDX) begin
        rx_shift_ff <= {rx_vote, rx_shift_ff[7:1]};
        if (rx_idx_ff == UARTS_LAST_DATA_IDX) begin
          rx_discard_ff <= flag_ff.rx_buffer_full_flag;
        end
      end else if (rx_idx_ff == UARTS_FIRST_TAIL_IDX && cfg_ff.pe) begin
        rx_par_ff <= rx_vote;
      end else if (!rx_vote) begin
        rx_stop_bad_ff <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      rx_prev_ff <= 1'b1;
    end else begin
      rx_prev_ff <= rx_filt_ff;
    end
  end

  // ************************************
  // receive buffer and status flags
  // ************************************
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      rx_buf_ff <= 8'h00;
    end else if (rx_load) begin
      rx_buf_ff <= rx_shift_ff;
    end
  end

  // only flags seen set by the last status read may be cleared
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      snap_ff <= '0;
    end else if (status_rd) begin
      snap_ff <= flag_ff;
    end else if (rxbuf_rd) begin
      snap_ff <= '0;
    end
  end

  // set wins over a clear landing in the same cycle
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      flag_ff <= '0;
    end else begin
      flag_ff.rx_buffer_full_flag <= rx_load | (flag_ff.rx_buffer_full_flag & ~(rxbuf_rd & snap_ff.rx_buffer_full_flag));
      flag_ff.parity_error_flag <= rx_parity_error_flag_set | (flag_ff.parity_error_flag & ~(rxbuf_rd & snap_ff.parity_error_flag));
      flag_ff.framing_error_flag <= rx_framing_error_flag_set | (flag_ff.framing_error_flag & ~(rxbuf_rd & snap_ff.framing_error_flag));
      flag_ff.overrun_error_flag <= rx_ovr_set | (flag_ff.overrun_error_flag & ~(rxbuf_rd & snap_ff.overrun_error_flag));
    end
  end

  // ************************************
  // transmitter
  // ************************************
  uarts_state_t tx_state_ff;
  logic [4:0] tx_cnt_ff;
  logic [3:0] tx_idx_ff;
  logic [7:0] tx_shift_ff;
  logic tx_par_ff;
  logic tx_bit;
  logic tx_start;
  logic tx_line_ff;
  logic tx_irq_ff;
  logic rx_irq_ff;

  assign tx_busy = (tx_state_ff == UARTS_BUSY);
  assign tx_start = (tx_state_ff == UARTS_IDLE) & tx_buffer_full_flag_ff & cfg_ff.txe & ~cfg_ff.lpm;

  always_comb begin
    if (tx_idx_ff == 4'h0) begin
      tx_bit = 1'b0;
    end else if (tx_idx_ff <= UARTS_LAST_DATA_IDX) begin
      tx_bit = tx_shift_ff[0];
    end else if (tx_idx_ff == UARTS_FIRST_TAIL_IDX && cfg_ff.pe) begin
      tx_bit = tx_par_ff;
    end else begin
      tx_bit = 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      tx_buf_ff <= 8'h00;
      tx_buffer_full_flag_ff <= 1'b0;
    end else begin
      if (txbuf_wr) begin
        tx_buf_ff <= pwdata_in[7:0];
      end
      // a write in the hand-off cycle is kept as the next byte
      if (txbuf_wr) begin
        tx_buffer_full_flag_ff <= 1'b1;
      end else if (tx_start) begin
        tx_buffer_full_flag_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      tx_state_ff <= UARTS_IDLE;
      tx_cnt_ff <= 5'h00;
      tx_idx_ff <= 4'h0;
      tx_shift_ff <= 8'h00;
      tx_par_ff <= 1'b0;
    end else if (!cfg_ff.txe) begin
      tx_state_ff <= UARTS_IDLE;
    end else begin
      unique case (tx_state_ff)
        UARTS_IDLE: begin
          if (tx_start) begin
            tx_state_ff <= UARTS_BUSY;
            tx_shift_ff <= tx_buf_ff;
            tx_par_ff <= ^tx_buf_ff ^ cfg_ff.odd;
            tx_idx_ff <= 4'h0;
            tx_cnt_ff <= bit_top(ticks_per_bit_select_ff, 4'h0);
          end
        end
        UARTS_BUSY: begin
          if (tick) begin
            if (tx_cnt_ff != 5'h00) begin
              tx_cnt_ff <= tx_cnt_ff - 5'h01;
            end else if (tx_idx_ff == last_idx(cfg_ff)) begin
              tx_state_ff <= UARTS_IDLE;
            end else begin
              if (tx_idx_ff != 4'h0 && tx_idx_ff <= UARTS_LAST_DATA_IDX) begin
                tx_shift_ff <= {1'b0, tx_shift_ff[7:1]};
              end
              tx_idx_ff <= tx_idx_ff + 4'h1;
              tx_cnt_ff <= bit_top(ticks_per_bit_select_ff, tx_idx_ff + 4'h1);
            end
          end
        end
      endcase
    end
  end

  // infrared mode inverts the line, so its idle level is low
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      tx_line_ff <= 1'b1;
    end else if (!cfg_ff.txe || cfg_ff.lpm || !tx_busy) begin
      tx_line_ff <= ~cfg_ff.irda;
    end else begin
      tx_line_ff <= tx_bit ^ cfg_ff.irda;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      tx_irq_ff <= 1'b0;
      rx_irq_ff <= 1'b0;
    end else begin
      tx_irq_ff <= tx_start;
      rx_irq_ff <= rx_irq;
    end
  end

  assign prdata_out = prdata_ff;
  assign pready_out = pready_ff;
  assign pslverr_out = pslverr_ff;
  assign serial_tx_pin_out = tx_line_ff;
  assign tx_interrupt_request_out = tx_irq_ff;
  assign rx_interrupt_request_out = rx_irq_ff;

endmodule

//--- hw/uarts_pkg.sv
// uarts_pkg: register map, field positions, reset values and shared types
// of the asynchronous serial transceiver core.
// assumes a 32-bit APB slave with word-aligned registers.
package uarts_pkg;

  // ************************************
  // register byte offsets
  // ************************************
  localparam logic [7:0] UARTS_CTRL_ONE_OFS = 8'h00;
  localparam logic [7:0] UARTS_CTRL_TWO_OFS = 8'h04;
  localparam logic [7:0] UARTS_DIVISOR_OFS = 8'h08;
  localparam logic [7:0] UARTS_STATUS_OFS = 8'h0C;
  localparam logic [7:0] UARTS_TX_BUF_OFS = 8'h10;
  localparam logic [7:0] UARTS_RX_BUF_OFS = 8'h14;

  // ************************************
  // control one fields
  // ************************************
  localparam int UARTS_C1_TXE = 0;
  localparam int UARTS_C1_RXE = 1;
  localparam int UARTS_C1_PE = 2;
  localparam int UARTS_C1_ODD = 3;
  localparam int UARTS_C1_STB = 4;
  localparam int UARTS_C1_IRDA = 5;
  localparam int UARTS_C1_LPM = 6;
  localparam int UARTS_C1_BRG_LO = 8;
  // control two fields
  localparam int UARTS_C2_RTS_LO = 0;
  localparam int UARTS_C2_NF_LO = 3;
  // status fields
  localparam int UARTS_ST_RX_BUFFER_FULL_FLAG = 0;
  localparam int UARTS_ST_PARITY_ERROR_FLAG = 1;
  localparam int UARTS_ST_FRAMING_ERROR_FLAG = 2;
  localparam int UARTS_ST_OVERRUN_ERROR_FLAG = 3;
  localparam int UARTS_ST_TX_BUFFER_FULL_FLAG = 4;
  localparam int UARTS_ST_TBSY = 5;

  // ************************************
  // reset values and counts
  // ************************************
  localparam logic [7:0] UARTS_DIVISOR_RST = 8'h00;
  localparam logic [4:0] UARTS_SAMPLE_A = 5'h08;
  localparam logic [4:0] UARTS_SAMPLE_B = 5'h07;
  localparam logic [4:0] UARTS_SAMPLE_C = 5'h06;
  localparam logic [3:0] UARTS_LAST_DATA_IDX = 4'h8;
  localparam logic [3:0] UARTS_FIRST_TAIL_IDX = 4'h9;

  typedef struct packed {
    logic [1:0] baud_clock_source_select;
    logic lpm;
    logic irda;
    logic stb;
    logic odd;
    logic pe;
    logic receive_enable_bit;
    logic txe;
  } uarts_cfg_t;

  typedef struct packed {
    logic overrun_error_flag;
    logic framing_error_flag;
    logic parity_error_flag;
    logic rx_buffer_full_flag;
  } uarts_rxflag_t;

endpackage

//--- test/test_uarts_core.sv
// test_uarts_core: apb-driven bench for the serial core with a peer model.
// assumes divisor 0 and base clock undivided, so one bit_tick per cycle.
`timescale 1ns/1ns
module test_uarts_core import uarts_pkg::*;;
  logic clk_in, rst_n_in, psel, penable, pwrite, pready, pslverr;
  logic rx_pin, tx_pin, tx_irq, rx_irq, e, ok;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [10:0] f;
  logic [2:0] rts [5] = '{3'h0, 3'h2, 3'h4, 3'h3, 3'h1};
  int tk0 [5] = '{16, 15, 17, 15, 16};
  int tk1 [5] = '{16, 15, 17, 16, 17};
  int err_total = 0;
  int tests_run = 0;
  int n_tx = 0;
  int n_rx = 0;
  int base;
  uarts_core i_dut (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .serial_rx_pin_in(rx_pin),
    .serial_tx_pin_out(tx_pin), .tx_interrupt_request_out(tx_irq),
    .rx_interrupt_request_out(rx_irq)
  );
  uarts_peer i_peer (.clk_in(clk_in), .tx_line_in(tx_pin), .rx_line_out(rx_pin));
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    n_tx += int'(tx_irq === 1'b1);
    n_rx += int'(rx_irq === 1'b1);
  end
  // ************************************
  // access and compare tasks
  // ************************************
  task automatic complete_run;
    $display("checks %0d errors %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    tests_run++;
    if (g !== x) begin
      $display("ERROR %s expected %h seen %h", nm, x, g);
      err_total++;
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_in);
    if (n >= 20) begin
      err_total++;
      complete_run;
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, x, r);
  endtask
  // ************************************
  // main sequence
  // ************************************
  initial begin
    rst_n_in = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (8) @(posedge clk_in);
    rst_n_in <= 1'b1;
    @(posedge clk_in);
    rd(UARTS_CTRL_ONE_OFS, 32'h0, "ctrl_one");
    rd(8'h18, 32'h0, "unmapped_data");
    chk("unmapped_err", 32'h1, {31'h0, e});
    chk("tx_idle", 32'h1, {31'h0, tx_pin});
    apb(1'b1, UARTS_CTRL_ONE_OFS, 32'h21);
    // the line register takes the new idle level one cycle after the write lands
    @(posedge clk_in);
    chk("tx_idle_ir", 32'h0, {31'h0, tx_pin});
    // two writes while disabled, only the newer may go out
    apb(1'b1, UARTS_CTRL_ONE_OFS, 32'h04);
    apb(1'b1, UARTS_TX_BUF_OFS, 32'h11);
    apb(1'b1, UARTS_TX_BUF_OFS, 32'hC3);
    rd(UARTS_STATUS_OFS, 32'h10, "tx_full");
    base = n_tx;
    apb(1'b1, UARTS_CTRL_ONE_OFS, 32'h05);
    i_peer.capture(f, ok);
    chk("tx_seen", 32'h1, {31'h0, ok});
    chk("tx_frame", {21'h0, 1'b1, 1'b0, 8'hC3, 1'b0}, {21'h0, f});
    chk("tx_irq", 32'd1, n_tx - base);
    rd(UARTS_STATUS_OFS, 32'h00, "tx_full_clr");
    apb(1'b1, UARTS_CTRL_ONE_OFS, 32'h06);
    // tick-count codes 0 to 4 and every filter code, status then buffer clears
    for (int k = 0; k < 5; k++) begin
      apb(1'b1, UARTS_CTRL_TWO_OFS, {27'h0, k[1:0], rts[k]});
      i_peer.send(8'h5A ^ k[7:0], 1'b0, 1'b1, tk0[k], tk1[k]);
      rd(UARTS_STATUS_OFS, 32'h01, "rx_full");
      rd(UARTS_RX_BUF_OFS, 32'h5A ^ k, "rx_data");
      rd(UARTS_STATUS_OFS, 32'h00, "rx_clr");
    end
    // widest filter: a three-cycle low pulse never reaches the receiver
    apb(1'b1, UARTS_CTRL_TWO_OFS, 32'h18);
    i_peer.glitch(3);
    rd(UARTS_STATUS_OFS, 32'h00, "filter_reject");
    apb(1'b1, UARTS_CTRL_TWO_OFS, 32'h0);
    i_peer.glitch(3);
    i_peer.send(8'h96, 1'b0, 1'b1, 16, 16);
    rd(UARTS_STATUS_OFS, 32'h01, "glitch_flags");
    rd(UARTS_RX_BUF_OFS, 32'h96, "glitch_data");
    i_peer.send(8'h3C, 1'b1, 1'b1, 16, 16);
    rd(UARTS_STATUS_OFS, 32'h03, "parity_err");
    apb(1'b0, UARTS_RX_BUF_OFS, 32'h0);
    i_peer.send(8'h3C, 1'b0, 1'b0, 16, 16);
    rd(UARTS_STATUS_OFS, 32'h05, "framing_err");
    apb(1'b0, UARTS_RX_BUF_OFS, 32'h0);
    rd(UARTS_STATUS_OFS, 32'h00, "err_clr");
    base = n_rx;
    i_peer.send(8'hA1, 1'b0, 1'b1, 16, 16);
    i_peer.send(8'hB2, 1'b0, 1'b1, 16, 16);
    i_peer.send(8'hC4, 1'b1, 1'b1, 16, 16);
    chk("rx_irq", 32'd2, n_rx - base);
    rd(UARTS_STATUS_OFS, 32'h09, "overrun");
    rd(UARTS_RX_BUF_OFS, 32'hA1, "kept_data");
    rd(UARTS_STATUS_OFS, 32'h00, "ovr_clr");
    i_peer.send(8'h77, 1'b0, 1'b1, 16, 16);
    apb(1'b0, UARTS_RX_BUF_OFS, 32'h0);
    rd(UARTS_STATUS_OFS, 32'h01, "no_snapshot");
    rd(UARTS_RX_BUF_OFS, 32'h77, "late_data");
    rd(UARTS_STATUS_OFS, 32'h00, "final_clr");
    // odd parity, two stops; wait out the second stop bit
    apb(1'b1, UARTS_CTRL_ONE_OFS, 32'h1E);
    i_peer.send(8'h3C, 1'b1, 1'b1, 16, 16);
    repeat (20) @(posedge clk_in);
    rd(UARTS_STATUS_OFS, 32'h01, "odd_two_stop");
    rd(UARTS_RX_BUF_OFS, 32'h3C, "odd_data");
    complete_run;
  end
endmodule

//--- test/uarts_core_assertions.sv
// uarts_core_assertions: port-level timing checks of the serial core.
// assumes it is bound to uarts_core, one clock, synchronous reset.
`timescale 1ns/1ns
module uarts_chk (
  input wire logic clk_in, // clock
  input wire logic rst_n_in, // reset, active low
  input wire logic psel_in, // apb select
  input wire logic penable_in, // apb enable
  input wire logic pwrite_in, // apb direction
  input wire logic [31:0] prdata_out, // read data
  input wire logic pready_out, // ready
  input wire logic pslverr_out, // error
  input wire logic serial_tx_pin_out, // tx line
  input wire logic tx_interrupt_request_out, // tx request
  input wire logic rx_interrupt_request_out // rx request
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // ************************************
  // apb timing
  // ************************************
  ready_pulse_a: assert property (pready_out |=> !pready_out)
    else $error("ready longer than one cycle");
  ready_wait_a: assert property ($rose(penable_in) && psel_in |=> pready_out)
    else $error("ready not one cycle into access");
  ready_cause_a: assert property (pready_out |-> psel_in && penable_in && $past(penable_in))
    else $error("ready without access phase");
  err_ready_a: assert property (pslverr_out |-> pready_out)
    else $error("error without ready");
  err_data_a: assert property (pslverr_out && !pwrite_in |-> prdata_out == 32'h0)
    else $error("error read data not zero");
  upper_zero_a: assert property (pready_out && !pwrite_in |-> prdata_out[31:10] == 22'h0)
    else $error("unused read bits set");
  // ************************************
  // serial events
  // ************************************
  tx_req_pulse_a: assert property (tx_interrupt_request_out |=> !tx_interrupt_request_out)
    else $error("tx request longer than one cycle");
  rx_req_pulse_a: assert property (rx_interrupt_request_out |=> !rx_interrupt_request_out)
    else $error("rx request longer than one cycle");
  // the line register follows the busy state, so the start bit trails the request by one cycle
  tx_start_a: assert property (tx_interrupt_request_out |=> $changed(serial_tx_pin_out))
    else $error("tx request without start bit");
  start_hold_a: assert property (tx_interrupt_request_out |=> ##1 ($stable(serial_tx_pin_out))[*8])
    else $error("start bit too short");
  cover property (tx_interrupt_request_out);
  cover property (rx_interrupt_request_out);
  cover property (pslverr_out);
endmodule

bind uarts_core uarts_chk u_chk (
  .clk_in(clk_in),
  .rst_n_in(rst_n_in),
  .psel_in(psel_in),
  .penable_in(penable_in),
  .pwrite_in(pwrite_in),
  .prdata_out(prdata_out),
  .pready_out(pready_out),
  .pslverr_out(pslverr_out),
  .serial_tx_pin_out(serial_tx_pin_out),
  .tx_interrupt_request_out(tx_interrupt_request_out),
  .rx_interrupt_request_out(rx_interrupt_request_out)
);

//--- test/uarts_peer.sv
// uarts_peer: remote serial party, drives the rx line and decodes tx.
// assumes one bit_tick per clk_in cycle (divisor 0, base clock undivided).
`timescale 1ns/1ns
module uarts_peer (
  input wire logic clk_in, // bench clock
  input wire logic tx_line_in, // core transmit line
  output logic rx_line_out // core receive line, idle high
);
  initial rx_line_out = 1'b1;
  // ************************************
  // frame sender, even parity unless pf is set, one stop
  // ************************************
  task automatic send(input logic [7:0] d, input logic pf, input logic stp,
                      input int t0, input int t1);
    logic [10:0] f;
    f = {stp, ^d ^ pf, d, 1'b0}; // lsb first
    for (int i = 0; i < 11; i++) begin
      rx_line_out <= f[i];
      repeat ((i % 2) ? t1 : t0) @(posedge clk_in);
    end
    rx_line_out <= 1'b1;
    repeat (4) @(posedge clk_in);
  endtask
  // short low pulse, too brief to survive start-bit sampling
  task automatic glitch(input int n);
    rx_line_out <= 1'b0;
    repeat (n) @(posedge clk_in);
    rx_line_out <= 1'b1;
    repeat (40) @(posedge clk_in);
  endtask
  // ************************************
  // frame decoder, 16 ticks per bit
  // ************************************
  task automatic capture(output logic [10:0] f, output logic ok);
    int n;
    n = 0;
    while (tx_line_in !== 1'b0 && n < 2000) begin
      @(posedge clk_in);
      n++;
    end
    ok = (n < 2000);
    repeat (8) @(posedge clk_in);
    for (int i = 0; i < 11; i++) begin
      f[i] = tx_line_in; // mid-bit sample, lsb first
      repeat (16) @(posedge clk_in);
    end
  endtask
endmodule
